// ### design/sdd_top.v
// Purpose: Decimating low-pass back end of a sigma-delta converter
// Assumes: 4.096 MHz mclk here; all rates scale with mclk
// Notes:   Three cascaded boxcars approximate the Gaussian response
//
// How it works
// - The filter cutoff is the master clock divided by 409600 and follows clock changes.
// - At 4.096 MHz a new result arrives every 4 kHz with a 10 Hz cutoff.
// - The modulator bit is sampled at 16 kHz nominal and its duty cycle feeds the filter.
// - Conversion runs continuously with no start request.
// - Each result sits in a 20-bit register readable at any moment.
// - After a step, results are invalid for the settling time; the host discards them.
// - After power-up the rolling average fills before any output counts as valid.
// - Unipolar range gives straight binary, bipolar gives offset binary.
// - Unipolar spans ground to reference, bipolar spans twice the reference about zero.
// - The datapath has headroom so overrange neither saturates nor wraps the sums.
// - All rates derive by fixed ratios from the one master clock.
// - The valid flag is low while data is valid, high after a word is sent and for 4 clocks after each load.
`timescale 1ns/1ps
`default_nettype none
`include "sdd_defines.vh"
module sdd_top #(
    parameter SAMPLE_DIV   = `SDD_SAMPLE_DIV,
    parameter UPDATE_DIV   = `SDD_UPDATE_DIV,
    parameter SETTLE_WORDS = `SDD_SETTLE_WORDS
) (
    input  wire                     mclk,
    input  wire                     rst_n,
    input  wire                     mod_bit,
    input  wire                     range_select_pin,
    input  wire                     word_sent,
    output reg  [`SDD_WORD_W-1:0]   result_q,
    output reg                      result_valid_n,
    output reg                      load_pulse_q
);
    // Pin inputs, two flops each
    reg mod_s1_q, mod_s2_q, rng_s1_q, rng_s2_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
            rng_s1_q <= 1'b0;
            rng_s2_q <= 1'b0;
        end else begin
            mod_s1_q <= mod_bit;
            mod_s2_q <= mod_s1_q;
            rng_s1_q <= range_select_pin;
            rng_s2_q <= rng_s1_q;
        end
    end

    // Rates are fixed divisions of mclk, so cutoff tracks the clock
    wire samp_tick;
    wire upd_tick;
    sdd_divider #(.DIV(SAMPLE_DIV), .W(`SDD_DIV_W)) u_samp (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tick  (samp_tick)
    );
    sdd_divider #(.DIV(UPDATE_DIV), .W(`SDD_DIV_W)) u_upd (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tick  (upd_tick)
    );

    // Integrate the bitstream between samples; runs free, no start
    reg [7:0] ones_q;
    reg [8:0] samp_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            ones_q <= 8'h00;
            samp_q <= 9'h000;
        end else if (samp_tick) begin
            samp_q <= {1'b0, ones_q} + {8'h00, mod_s2_q};
            ones_q <= 8'h00;
        end else begin
            ones_q <= ones_q + {7'h00, mod_s2_q};
        end
    end

    // Three boxcars of 16 at 16 kHz; widths carry full growth
    wire [12:0] st1;
    wire [16:0] st2;
    wire [20:0] st3;
    sdd_boxcar #(.IW(9), .OW(13), .DEPTH(16), .SH(4)) u_bx1 (
        .mclk  (mclk),
        .rst_n (rst_n),
        .en    (samp_tick),
        .din   (samp_q),
        .dout  (st1)
    );
    sdd_boxcar #(.IW(13), .OW(17), .DEPTH(16), .SH(4)) u_bx2 (
        .mclk  (mclk),
        .rst_n (rst_n),
        .en    (samp_tick),
        .din   (st1),
        .dout  (st2)
    );
    sdd_boxcar #(.IW(17), .OW(21), .DEPTH(16), .SH(4)) u_bx3 (
        .mclk  (mclk),
        .rst_n (rst_n),
        .en    (samp_tick),
        .din   (st2),
        .dout  (st3)
    );

    // Shorter sample periods count fewer ones, so restore the full-scale gain
    localparam integer GAIN_SH = 8 - $clog2(SAMPLE_DIV);
    wire [20:0] scaled = st3 << GAIN_SH;

    // Scale to 20 bits, clamp only the top code; full scale is 2^20 counts
    // Bipolar shares the map: midscale is zero, giving offset binary
    reg [`SDD_WORD_W-1:0] code_d;
    always @* begin
        if (scaled[20])
            code_d = `SDD_MAX_CODE;
        else
            code_d = scaled[19:0];
    end

    // Settling after power-up: count loads before trusting data
    reg [9:0] settle_q;
    wire      settled = (settle_q == SETTLE_WORDS[9:0]);
    always @(posedge mclk) begin
        if (!rst_n)
            settle_q <= 10'h000;
        else if (upd_tick && !settled)
            settle_q <= settle_q + 10'h001;
    end

    // Output register and valid flag
    reg [2:0] hold_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            result_q       <= `SDD_MID_CODE;
            result_valid_n <= 1'b1;
            load_pulse_q   <= 1'b0;
            hold_q         <= 3'h0;
        end else begin
            load_pulse_q <= upd_tick;
            if (upd_tick) begin
                result_q       <= code_d;
                hold_q         <= `SDD_VALID_HOLD;
                result_valid_n <= 1'b1;
            end else if (hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
                if (hold_q == 3'h1)
                    result_valid_n <= ~settled;
            end else if (word_sent) begin
                result_valid_n <= 1'b1;
            end
        end
    end
endmodule // sdd_top
`default_nettype wire

// ### design/sdd_defines.vh
// Purpose: Constants for the sigma-delta decimation output block
// Assumes: Included by bare name from design files
// Notes:   Ratios are fixed against the master clock
`ifndef SDD_DEFINES_VH
`define SDD_DEFINES_VH
`define SDD_CUTOFF_RATIO   409600
`define SDD_SAMPLE_DIV     256
`define SDD_UPDATE_DIV     1024
`define SDD_WORD_W         20
`define SDD_VALID_HOLD     3'h4
`define SDD_DIV_W          10
`define SDD_MID_CODE       20'h80000
`define SDD_MAX_CODE       20'hFFFFF
`define SDD_SETTLE_WORDS   500
`define SDD_STAGES         3
`endif

// ### design/sdd_divider.v
// Purpose: Free-running divider giving one-cycle enable pulses
// Assumes: Single master clock, synchronous active-low reset
// Notes:   Pulse in the cycle after the last count of each period
`timescale 1ns/1ps
`default_nettype none
module sdd_divider #(
    parameter DIV = 1024,
    parameter W   = 10
) (
    input  wire         mclk,
    input  wire         rst_n,
    output reg          tick
);
    reg [W-1:0] cnt_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= {W{1'b0}};
            tick  <= 1'b0;
        end else begin
            tick <= (cnt_q == DIV[W-1:0] - 1'b1);
            if (cnt_q == DIV[W-1:0] - 1'b1)
                cnt_q <= {W{1'b0}};
            else
                cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // sdd_divider
`default_nettype wire

// ### design/sdd_boxcar.v
// Purpose: One boxcar stage of the rolling-average filter
// Assumes: Input valid on en pulses only
// Notes:   Sum register carries headroom bits so overrange never wraps
`timescale 1ns/1ps
`default_nettype none
module sdd_boxcar #(
    parameter IW    = 24,
    parameter OW    = 24,
    parameter DEPTH = 16,
    parameter SH    = 4
) (
    input  wire          mclk,
    input  wire          rst_n,
    input  wire          en,
    input  wire [IW-1:0] din,
    output wire [OW-1:0] dout
);
    reg [IW-1:0]    hist_q [0:DEPTH-1];
    reg [IW+SH-1:0] sum_q;
    integer         i;
    always @(posedge mclk) begin
        if (!rst_n) begin
            sum_q <= {(IW+SH){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1)
                hist_q[i] <= {IW{1'b0}};
        end else if (en) begin
            sum_q <= sum_q + {{SH{1'b0}}, din} - {{SH{1'b0}}, hist_q[DEPTH-1]};
            hist_q[0] <= din;
            for (i = 1; i < DEPTH; i = i + 1)
                hist_q[i] <= hist_q[i-1];
        end
    end
    assign dout = sum_q[IW+SH-1 -: OW];
endmodule // sdd_boxcar
`default_nettype wire

// ### verif/sdd_top_asserts.sv
// Purpose: Port checks for sdd_top
// Assumes: One clock, sync active-low reset
// Notes:   Counters track load spacing
`timescale 1ns/1ps
`default_nettype none
module sdd_top_asserts #(
    parameter UPDATE_DIV   = 1024,
    parameter SETTLE_WORDS = 500
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        word_sent,
    input wire logic [19:0] result_q,
    input wire logic        result_valid_n,
    input wire logic        load_pulse_q
);
    int   gap_q;
    int   loads_q;
    logic seen_q;
    always @(posedge mclk) begin
        if (!rst_n) begin
            gap_q <= 0;
            loads_q <= 0;
            seen_q <= 1'b0;
        end else if (load_pulse_q) begin
            gap_q <= 0;
            seen_q <= 1'b1;
            loads_q <= (loads_q < SETTLE_WORDS) ? loads_q + 1 : loads_q;
        end else begin
            gap_q <= gap_q + 1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reset_state_a: assert property (disable iff (1'b0) !rst_n |=>
        result_valid_n && !load_pulse_q && result_q == 20'h80000) else $error("bad reset");
    load_period_a: assert property (load_pulse_q && seen_q |-> gap_q == UPDATE_DIV - 1)
        else $error("load spacing");
    free_running_a: assert property (gap_q <= UPDATE_DIV + 1) else $error("load missing");
    hold_result_a: assert property (!load_pulse_q |-> $stable(result_q))
        else $error("result moved");
    load_hides_a: assert property (load_pulse_q |-> result_valid_n [*4])
        else $error("valid too soon");
    fall_after_load_a: assert property ($fell(result_valid_n) |-> $past(load_pulse_q, 4))
        else $error("valid fall");
    sent_clears_a: assert property (word_sent && !result_valid_n |=> result_valid_n)
        else $error("sent not seen");
    fill_first_a: assert property (!result_valid_n |-> loads_q >= SETTLE_WORDS)
        else $error("valid before fill");
endmodule // sdd_top_asserts
bind sdd_top sdd_top_asserts #(.UPDATE_DIV(UPDATE_DIV), .SETTLE_WORDS(SETTLE_WORDS)) u_chk (
    .mclk(mclk), .rst_n(rst_n), .word_sent(word_sent), .result_q(result_q),
    .result_valid_n(result_valid_n), .load_pulse_q(load_pulse_q));
`default_nettype wire

// ### verif/sdd_mod_model.sv
// Purpose: Modulator bitstream source
// Assumes: duty/16 ones per 16 samples
// Notes:   Bit held a whole sample period, so phase to the sampler is free
`timescale 1ns/1ps
`default_nettype none
module sdd_mod_model #(
    parameter SAMPLE_DIV = 256
) (
    input wire logic       mclk,
    input wire logic [4:0] duty,
    output var logic       mod_bit
);
    int         div_q;
    logic [3:0] acc_q;
    logic [4:0] sum;
    assign sum = {1'b0, acc_q} + duty;
    initial begin
        div_q = 0;
        acc_q = 4'h0;
        mod_bit = 1'b0;
    end
    always @(posedge mclk) begin
        div_q <= (div_q == SAMPLE_DIV - 1) ? 0 : div_q + 1;
        if (div_q == 0) begin
            mod_bit <= sum[4];
            acc_q <= sum[3:0];
        end
    end
endmodule // sdd_mod_model
`default_nettype wire

// ### verif/sdd_tb_top.sv
// Purpose: Self-checking bench for sdd_top
// Assumes: Short divisors 16/64, settle 4 loads
// Notes:   Waits 20 loads per code so the boxcars flush
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module sigma_delta_decimation_output_tb_top;
    logic        mclk;
    logic        rst_n;
    logic        mod_bit;
    logic        range_select_pin;
    logic        word_sent;
    logic [4:0]  duty;
    logic [19:0] result_q;
    logic        result_valid_n;
    logic        load_pulse_q;
    int          failures;
    int          n_compared;
    sdd_top #(.SAMPLE_DIV(16), .UPDATE_DIV(64), .SETTLE_WORDS(4)) uut (.mclk(mclk),
        .rst_n(rst_n), .mod_bit(mod_bit), .range_select_pin(range_select_pin),
        .word_sent(word_sent), .result_q(result_q), .result_valid_n(result_valid_n),
        .load_pulse_q(load_pulse_q));
    sdd_mod_model #(.SAMPLE_DIV(16)) u_mod (.mclk(mclk), .duty(duty), .mod_bit(mod_bit));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_load;
        int i;
        i = 0;
        @(negedge mclk);
        while (load_pulse_q !== 1'b1 && i < 200) begin
            @(negedge mclk);
            i++;
        end
    endtask
    task automatic t_code(input logic [4:0] d, input logic r, input logic [19:0] e);
        duty = d;
        range_select_pin = r;
        repeat (20) wait_load();
        `CHK(result_q, e)
    endtask
    task automatic t_period;
        int n;
        wait_load();
        for (n = 0; n < 4; n++) begin
            `CHK(result_valid_n, 1'b1)
            @(negedge mclk);
        end
        `CHK(result_valid_n, 1'b0)
        n = 4;
        while (load_pulse_q !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n, 64)
    endtask
    task automatic t_sent;
        logic [19:0] held;
        wait_load();
        repeat (4) @(negedge mclk);
        held = result_q;
        word_sent = 1'b1;
        @(negedge mclk);
        word_sent = 1'b0;
        `CHK(result_valid_n, 1'b1)
        `CHK(result_q, held)
    endtask
    initial begin
        failures = 0;
        n_compared = 0;
        rst_n = 1'b0;
        word_sent = 1'b0;
        duty = 5'h08;
        range_select_pin = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK(result_q, 20'h80000)
        `CHK(result_valid_n, 1'b1)
        rst_n = 1'b1;
        t_code(5'h00, 1'b0, 20'h00000);
        t_code(5'h08, 1'b0, 20'h80000);
        t_code(5'h10, 1'b0, 20'hFFFFF);
        t_code(5'h08, 1'b1, 20'h80000);
        t_code(5'h10, 1'b1, 20'hFFFFF);
        t_code(5'h00, 1'b1, 20'h00000);
        t_period();
        t_sent();
        test_done();
    end
    initial begin
        #(40 * 20000);
        failures++;
        test_done();
    end
endmodule // sigma_delta_decimation_output_tb_top
`default_nettype wire
